/* File: logic/sacs_defs.svh */
// Timing, width and reset constants of the conversion sequencer.
// Assumes the core clock period given below and is included by sacs_pkg.
`ifndef SACS_DEFS_SVH
`define SACS_DEFS_SVH

`define SACS_CLK_NS      4
`define SACS_HOLD_NS     120
`define SACS_COARSE_NS   220
`define SACS_RESULT_NS   330
`define SACS_PD_NS       530
`define SACS_PUP_EXT_NS  1000
`define SACS_PUP_INT_NS  25000

`define SACS_HOLD_CYC    ((`SACS_HOLD_NS + `SACS_CLK_NS - 1) / `SACS_CLK_NS)
`define SACS_COARSE_CYC  (`SACS_COARSE_NS / `SACS_CLK_NS)
`define SACS_RESULT_CYC  (`SACS_RESULT_NS / `SACS_CLK_NS)
`define SACS_PD_CYC      ((`SACS_PD_NS + `SACS_CLK_NS - 1) / `SACS_CLK_NS)
`define SACS_PUP_EXT_CYC (`SACS_PUP_EXT_NS / `SACS_CLK_NS)
`define SACS_PUP_INT_CYC (`SACS_PUP_INT_NS / `SACS_CLK_NS)

`define SACS_TMR_W       13
`define SACS_THERM_W     15
`define SACS_NIB_W       4
`define SACS_WORD_W      8
`define SACS_BCNT_W      4
`define SACS_BITS        8
`define SACS_CS_SYNC_RST 3'h7
`define SACS_FS_IDLE     1'h1

`endif

/* File: logic/sacs_pkg.sv */
// Types shared by the conversion sequencer and its serial port.
// Assumes sacs_defs.svh is on the include path.
`include "sacs_defs.svh"

package sacs_pkg;

    typedef logic [`SACS_TMR_W-1:0]   sacs_tmr_t;
    typedef logic [`SACS_THERM_W-1:0] sacs_therm_t;
    typedef logic [`SACS_NIB_W-1:0]   sacs_nib_t;
    typedef logic [`SACS_WORD_W-1:0]  sacs_word_t;
    typedef logic [`SACS_BCNT_W-1:0]  sacs_bcnt_t;

    typedef enum logic [6:0] {
        ST_OFF    = 7'h01,
        ST_PWRUP  = 7'h02,
        ST_IDLE   = 7'h04,
        ST_HOLD   = 7'h08,
        ST_COARSE = 7'h10,
        ST_FINE   = 7'h20,
        ST_TAIL   = 7'h40
    } sacs_state_e;

    typedef struct packed {
        logic th_hold;
        logic fine_sel;
        logic powered;
    } sacs_ana_s;

    typedef struct packed {
        logic frame_sync_out;
        logic dout;
        logic dout_oe;
    } sacs_ser_s;

endpackage

/* File: logic/sacs_serial.sv */
// Serial result port, clocked by the receiver's continuous serial clock.
// Assumes result is held stable by the core while data_tgl is in flight.
`timescale 1ns/100ps

module sacs_serial
    import sacs_pkg::*;
(
    input  wire logic       sclk,
    input  wire logic       srst,
    input  wire sacs_word_t result,
    input  wire logic       data_tgl,
    input  wire logic       abort_tgl,
    output sacs_ser_s       ser
);

    logic [1:0] rst_sync_reg;
    logic [2:0] dt_sync_reg;
    logic [2:0] ab_sync_reg;
    logic       rst_l;
    logic       new_data;
    logic       abort;
    logic       pend_reg;
    logic       pend_next;
    logic       fs_reg;
    logic       fs_next;
    logic       drive_reg;
    logic       drive_next;
    logic       dout_reg;
    logic       dout_next;
    logic       off_reg;
    logic       off_next;
    logic       start;
    sacs_word_t sh_reg;
    sacs_word_t sh_next;
    sacs_bcnt_t cnt_reg;
    sacs_bcnt_t cnt_next;

    assign rst_l    = rst_sync_reg[1];
    assign new_data = dt_sync_reg[2] ^ dt_sync_reg[1];
    assign abort    = ab_sync_reg[2] ^ ab_sync_reg[1];

    always_ff @(posedge sclk) begin
        rst_sync_reg <= {rst_sync_reg[0], srst};
        dt_sync_reg  <= {dt_sync_reg[1:0], data_tgl};
        ab_sync_reg  <= {ab_sync_reg[1:0], abort_tgl};
    end

    always_comb begin
        start      = pend_reg && (cnt_reg == 4'h0);
        pend_next  = new_data || (pend_reg && !start);
        fs_next    = fs_reg;
        drive_next = drive_reg;
        dout_next  = dout_reg;
        sh_next    = sh_reg;
        cnt_next   = cnt_reg;
        if (abort) begin
            // A new conversion start ends a frame that lost its closing clock.
            fs_next    = `SACS_FS_IDLE;
            drive_next = 1'h0;
            cnt_next   = 4'h0;
        end else if (start) begin
            // Fourth edge after the result toggle, past the toggle sync and pending flag: frame low and MSB out.
            fs_next    = 1'h0;
            drive_next = 1'h1;
            sh_next    = result;
            dout_next  = result[`SACS_WORD_W-1];
            cnt_next   = 4'h1;
        end else if (cnt_reg == 4'(`SACS_BITS)) begin
            // Ninth edge closes the frame.
            fs_next    = `SACS_FS_IDLE;
            drive_next = 1'h0;
            cnt_next   = 4'h0;
        end else if (cnt_reg != 4'h0) begin
            sh_next   = {sh_reg[`SACS_WORD_W-2:0], 1'h0};
            dout_next = sh_reg[`SACS_WORD_W-2];
            cnt_next  = cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge sclk) begin
        if (rst_l) begin
            pend_reg  <= 1'h0;
            fs_reg    <= `SACS_FS_IDLE;
            drive_reg <= 1'h0;
            dout_reg  <= 1'h0;
            sh_reg    <= 8'h00;
            cnt_reg   <= 4'h0;
        end else begin
            pend_reg  <= pend_next;
            fs_reg    <= fs_next;
            drive_reg <= drive_next;
            dout_reg  <= dout_next;
            sh_reg    <= sh_next;
            cnt_reg   <= cnt_next;
        end
    end

    // The output driver lets go on the falling edge of the eighth clock.
    always_comb begin
        off_next = (cnt_reg == 4'(`SACS_BITS));
    end

    always_ff @(negedge sclk) begin
        if (rst_l) begin
            off_reg <= 1'h0;
        end else begin
            off_reg <= off_next;
        end
    end

    // One driver for the whole carrier: frame sync, data bit, output enable.
    assign ser = {fs_reg, dout_reg, drive_reg && !off_reg};

endmodule

/* File: logic/sacs_top.sv */
// Conversion sequencer of an 8-bit half-flash sampling converter.
// Assumes one 15-comparator flash bank whose outputs are asynchronous,
// a continuous serial clock from the receiver, and a reference strap pin.
//
// How it works
// - A convert-start falling edge begins a conversion when fully powered.
// - Hold the sample 120 ns, then return to track and convert.
// - The coarse flash yields the four upper result bits.
// - The fine flash yields the lower four; the byte goes to the shifter.
// - Coarse step ends at 220 ns, result ready at 330 ns.
// - Tracking resumes after hold, overlapping acquisition with conversion.
// - Frame sync rests high outside an announced transfer.
// - First serial rising edge after the result drives frame sync low; here the fourth, after the toggle sync and pending flag.
// - After supply-on the core sits in low-current power-down.
// - A convert-start rising edge powers the core up.
// - Power-up takes 1 us with external, 25 us with on-chip reference.
// - An early falling edge defers the conversion until power-up ends.
// - A falling edge after power-up starts the conversion itself.
// - Result is straight binary, one code per whole step.
// - At 530 ns sample convert-start; low powers down, high stays up.
// - Data output drives MSB first, seven more bits on later edges.
// - Output floats at eighth falling edge; frame sync rises at ninth.
// - A missing ninth clock is cured by the next convert-start fall.
`timescale 1ns/100ps

module sacs_top
    import sacs_pkg::*;
#(
    parameter sacs_tmr_t PUP_INT_CYC = 13'(`SACS_PUP_INT_CYC)
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        sclk,
    input  wire logic        convert_start_n,
    input  wire logic        use_internal_ref,
    input  wire sacs_therm_t flash_therm,
    output sacs_ana_s        ana,
    output sacs_ser_s        ser
);

    logic [2:0]  cs_sync_reg;
    logic [2:0]  cs_sync_next;
    logic [1:0]  ref_sync_reg;
    logic [1:0]  ref_sync_next;
    sacs_therm_t th1_reg;
    sacs_therm_t th2_reg;
    logic        cs_lvl;
    logic        cs_fall;
    logic        cs_rise;
    sacs_tmr_t   pup_lim;

    sacs_state_e st_reg;
    sacs_state_e st_next;
    sacs_tmr_t   tmr_reg;
    sacs_tmr_t   tmr_next;
    logic        pend_reg;
    logic        pend_next;
    sacs_nib_t   coarse_reg;
    sacs_nib_t   coarse_next;
    sacs_word_t  res_reg;
    sacs_word_t  res_next;
    logic        dtg_reg;
    logic        dtg_next;
    logic        atg_reg;
    logic        atg_next;
    sacs_ana_s   ana_reg;
    sacs_ana_s   ana_next;

    // Counting the comparators that trip gives the binary code directly,
    // so every code boundary sits one whole step above the last.
    function automatic sacs_nib_t therm2bin(input sacs_therm_t t);
        sacs_nib_t n;
        n = 4'h0;
        for (int i = 0; i < `SACS_THERM_W; i++) begin
            n = n + {3'h0, t[i]};
        end
        return n;
    endfunction

    // Pin inputs pass two flops; the third convert-start flop is history.
    always_comb begin
        cs_sync_next  = {cs_sync_reg[1:0], convert_start_n};
        ref_sync_next = {ref_sync_reg[0], use_internal_ref};
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cs_sync_reg  <= `SACS_CS_SYNC_RST;
            ref_sync_reg <= 2'h0;
            th1_reg      <= 15'h0000;
            th2_reg      <= 15'h0000;
        end else begin
            cs_sync_reg  <= cs_sync_next;
            ref_sync_reg <= ref_sync_next;
            th1_reg      <= flash_therm;
            th2_reg      <= th1_reg;
        end
    end

    assign cs_lvl  = cs_sync_reg[1];
    assign cs_fall = cs_sync_reg[2] && !cs_sync_reg[1];
    assign cs_rise = !cs_sync_reg[2] && cs_sync_reg[1];

    // Power-up length follows the reference in use.
    assign pup_lim = ref_sync_reg[1] ? PUP_INT_CYC : 13'(`SACS_PUP_EXT_CYC);

    always_comb begin
        st_next     = st_reg;
        tmr_next    = tmr_reg + 13'h0001;
        pend_next   = pend_reg;
        coarse_next = coarse_reg;
        res_next    = res_reg;
        dtg_next    = dtg_reg;
        // Every falling edge tells the serial side to drop a stale frame.
        atg_next    = atg_reg ^ cs_fall;
        unique case (st_reg)
            ST_OFF: begin
                tmr_next  = 13'h0000;
                pend_next = 1'h0;
                if (cs_rise) begin
                    st_next = ST_PWRUP;
                end
            end
            ST_PWRUP: begin
                if (cs_fall) begin
                    pend_next = 1'h1;
                end
                if (tmr_reg == pup_lim - 13'h0001) begin
                    tmr_next  = 13'h0000;
                    pend_next = 1'h0;
                    // A deferred start runs the moment power-up ends.
                    if (pend_reg || cs_fall) begin
                        st_next = ST_HOLD;
                    end else begin
                        st_next = ST_IDLE;
                    end
                end
            end
            ST_IDLE: begin
                tmr_next = 13'h0000;
                if (cs_fall) begin
                    st_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Hold time counts from the accepted falling edge.
                if (tmr_reg == 13'(`SACS_HOLD_CYC - 1)) begin
                    st_next = ST_COARSE;
                end
            end
            ST_COARSE: begin
                if (tmr_reg == 13'(`SACS_COARSE_CYC - 1)) begin
                    coarse_next = therm2bin(th2_reg);
                    st_next     = ST_FINE;
                end
            end
            ST_FINE: begin
                if (tmr_reg == 13'(`SACS_RESULT_CYC - 1)) begin
                    res_next = {coarse_reg, therm2bin(th2_reg)};
                    dtg_next = !dtg_reg;
                    st_next  = ST_TAIL;
                end
            end
            ST_TAIL: begin
                // The convert-start level decides whether the core sleeps.
                if (tmr_reg == 13'(`SACS_PD_CYC - 1)) begin
                    if (cs_lvl) begin
                        st_next = ST_IDLE;
                    end else begin
                        st_next = ST_OFF;
                    end
                end
            end
            default: begin
                st_next = ST_OFF;
            end
        endcase
        // Conversion states take no notice of cs_fall; only atg_next still toggles on it.
    end

    always_comb begin
        ana_next.th_hold  = (st_next == ST_HOLD);
        ana_next.fine_sel = (st_next == ST_FINE);
        ana_next.powered  = (st_next != ST_OFF) && (st_next != ST_PWRUP);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg     <= ST_OFF;
            tmr_reg    <= 13'h0000;
            pend_reg   <= 1'h0;
            coarse_reg <= 4'h0;
            res_reg    <= 8'h00;
            dtg_reg    <= 1'h0;
            atg_reg    <= 1'h0;
            ana_reg    <= 3'h0;
        end else begin
            st_reg     <= st_next;
            tmr_reg    <= tmr_next;
            pend_reg   <= pend_next;
            coarse_reg <= coarse_next;
            res_reg    <= res_next;
            dtg_reg    <= dtg_next;
            atg_reg    <= atg_next;
            ana_reg    <= ana_next;
        end
    end

    assign ana = ana_reg;

    // The port has its own clock and keeps working while the core sleeps;
    // the result word is held steady until the next conversion ends.
    sacs_serial u_serial (
        .sclk      (sclk),
        .srst      (srst),
        .result    (res_reg),
        .data_tgl  (dtg_reg),
        .abort_tgl (atg_reg),
        .ser       (ser)
    );

endmodule

/* File: test/sacs_assertions.sv */
// Concurrent checks on the conversion sequencer top ports.
// Assumes a bind in the bench top file attaches it to sacs_top.
`timescale 1ns/100ps

module sacs_assertions
    import sacs_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        sclk,
    input wire logic        convert_start_n,
    input wire logic        use_internal_ref,
    input wire sacs_therm_t flash_therm,
    input wire sacs_ana_s   ana,
    input wire sacs_ser_s   ser
);
    sequence s_start;
        $rose(ana.th_hold);
    endsequence
    sequence s_frame8;
        $fell(ser.frame_sync_out) ##1 !ser.frame_sync_out [*7];
    endsequence
    property p_hold;
        @(posedge clk) disable iff (srst)
        s_start |-> ##29 ana.th_hold ##1 !ana.th_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("hold length wrong");
    property p_fine;
        @(posedge clk) disable iff (srst)
        s_start |-> ##55 $rose(ana.fine_sel) ##27 $fell(ana.fine_sel);
    endproperty
    a_fine: assert property (p_fine) else $error("step timing wrong");
    property p_gate;
        @(posedge clk) disable iff (srst) !ana.powered |-> !ana.th_hold && !ana.fine_sel;
    endproperty
    a_gate: assert property (p_gate) else $error("activity while off");
    property p_pup;
        @(posedge clk) disable iff (srst)
        ($rose(convert_start_n) && !ana.powered && !use_internal_ref)
            |-> ##240 !ana.powered ##[1:20] ana.powered;
    endproperty
    a_pup: assert property (p_pup) else $error("power-up time wrong");
    property p_pdown;
        @(posedge clk) disable iff (srst)
        (s_start ##124 !convert_start_n [*8]) |-> ##[1:6] !ana.powered;
    endproperty
    a_pdown: assert property (p_pdown) else $error("no power-down");
    property p_ign;
        @(posedge clk) disable iff (srst)
        ($fell(convert_start_n) && ana.fine_sel) |-> !ana.th_hold [*8];
    endproperty
    a_ign: assert property (p_ign) else $error("restart while busy");
    property p_abort;
        @(posedge clk) disable iff (srst)
        ($fell(convert_start_n) && !ser.frame_sync_out) |-> ##[1:250] ser.frame_sync_out;
    endproperty
    a_abort: assert property (p_abort) else $error("sync not forced high");
    property p_fs_oe;
        @(posedge sclk) disable iff (srst) $fell(ser.frame_sync_out) |-> ser.dout_oe;
    endproperty
    a_fs_oe: assert property (p_fs_oe) else $error("line not driven");
    property p_fs_end;
        @(posedge sclk) disable iff (srst)
        s_frame8 |-> ##1 (ser.frame_sync_out && !ser.dout_oe);
    endproperty
    a_fs_end: assert property (p_fs_end) else $error("frame end wrong");
    property p_oe_fs;
        @(posedge sclk) disable iff (srst) ser.dout_oe |-> !ser.frame_sync_out;
    endproperty
    a_oe_fs: assert property (p_oe_fs) else $error("drive outside frame");
endmodule

/* File: test/sacs_rx_model.sv */
// Serial receive port model: takes one bit per falling serial edge.
// Assumes a continuous serial clock from the bench.
`timescale 1ns/100ps

module sacs_rx_model
    import sacs_pkg::*;
(
    input  wire logic      sclk,
    input  wire sacs_ser_s ser,
    output sacs_word_t     rx_word,
    output int             rx_cnt
);
    logic       line;
    logic       last = 1'h0;
    int         nbit = 0;
    sacs_word_t shreg = 8'h00;

    // A released data line shows the inverse of its last driven level.
    assign line = ser.dout_oe ? ser.dout : ~last;
    initial rx_cnt = 0;
    initial rx_word = 8'h00;

    always @(negedge sclk) begin
        if (ser.frame_sync_out !== 1'h0) begin
            nbit = 0;
        end else if (nbit < 8) begin
            shreg = {shreg[6:0], line};
            last = line;
            nbit++;
            if (nbit == 8) begin
                rx_word = shreg;
                rx_cnt++;
            end
        end
    end
endmodule

/* File: test/sacs_top_test.sv */
// Self-checking bench of the conversion sequencer with a serial receiver.
// Assumes sacs_assertions and sacs_rx_model are compiled before it.
`timescale 1ns/100ps

module sacs_top_test
    import sacs_pkg::*;
;
    localparam int PUP_INT = 20;
    logic        clk = 1'h0;
    logic        sclk = 1'h0;
    logic        srst = 1'h1;
    logic        convert_start_n = 1'h0;
    logic        use_internal_ref = 1'h0;
    sacs_therm_t flash_therm = '0;
    sacs_ana_s   ana;
    sacs_ser_s   ser;
    sacs_word_t  rx_word;
    int          rx_cnt;
    int          seen = 0;
    int          error_cnt = 0;
    int          total_checks = 0;

    always #2 clk = ~clk;
    initial #1.3 forever #80 sclk = ~sclk;

    sacs_top #(.PUP_INT_CYC(sacs_tmr_t'(PUP_INT))) sacs_top_i (
        .clk(clk), .srst(srst), .sclk(sclk), .convert_start_n(convert_start_n),
        .use_internal_ref(use_internal_ref), .flash_therm(flash_therm),
        .ana(ana), .ser(ser));
    sacs_rx_model sacs_rx_model_i (.sclk(sclk), .ser(ser), .rx_word(rx_word),
        .rx_cnt(rx_cnt));

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #0.5;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        error_cnt++;
        $display("mismatch %0t %s", $time, m);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        total_checks++;
        if (got !== exp) fail(m);
    endtask
    task automatic chk_word(input sacs_word_t got, input sacs_word_t exp, input string m);
        total_checks++;
        if (got !== exp) fail(m);
    endtask
    task automatic chk_rng(input int v, input int lo, input int hi, input string m);
        total_checks++;
        if (v < lo || v > hi) fail(m);
    endtask
    // Waits on a selected condition under a cycle bound.
    task automatic wait_on(input int sel, output int k);
        k = 0;
        while (!(sel == 0 ? ana.th_hold === 1'h1 : sel == 1 ? ana.powered === 1'h1 :
                 sel == 2 ? ana.fine_sel === 1'h1 : sel == 3 ? rx_cnt != seen :
                 ser.frame_sync_out === 1'h0) && k < 3000) begin
            tick(1);
            k++;
        end
        if (k >= 3000) begin
            fail("wait ran out");
            complete_run();
        end
    endtask
    function automatic sacs_therm_t therm(input sacs_nib_t v);
        return sacs_therm_t'((16'h0001 << v) - 16'h0001);
    endfunction
    // One conversion; keep high leaves the core powered after it.
    task automatic conv(input sacs_word_t w, input logic keep);
        int k;
        int lim;
        seen = rx_cnt;
        flash_therm = therm(w[7:4]);
        convert_start_n = 1'h0;
        wait_on(0, k);
        chk_rng(k, 1, 6, "start latency");
        wait_on(2, k);
        flash_therm = therm(w[3:0]);
        convert_start_n = 1'h1;
        tick(3);
        convert_start_n = keep;
        tick(100);
        chk_bit(ana.powered, keep, "power after sample");
        wait_on(3, k);
        chk_word(rx_word, w, "received word");
        tick(20);
        convert_start_n = 1'h1;
        lim = use_internal_ref ? PUP_INT : 250;
        wait_on(1, k);
        if (!keep) chk_rng(k, lim, lim + 12, "power-up time");
        // Lets an edge pass so the next start never lands in this time step.
        tick(1);
    endtask

    initial begin
        int k;
        void'($urandom(15163));
        repeat (5) @(posedge sclk);
        tick(1);
        srst = 1'h0;
        chk_bit(ana.powered, 1'h0, "not off at start");
        chk_bit(ser.frame_sync_out, 1'h1, "sync not idle");
        chk_bit(ser.dout_oe, 1'h0, "line driven");
        tick(3);
        convert_start_n = 1'h1;
        tick(40);
        convert_start_n = 1'h0;
        wait_on(0, k);
        chk_rng(k, 200, 225, "deferred start");
        convert_start_n = 1'h1;
        wait_on(3, k);
        chk_word(rx_word, 8'h00, "zero word");
        $display("test deferred done");
        tick(20);
        for (int i = 0; i < 10; i++) begin
            if (i == 6) use_internal_ref = 1'h1;
            conv(i == 0 ? 8'hFF : sacs_word_t'($urandom), i[0]);
            $display("test conv %0d done", i);
        end
        seen = rx_cnt;
        convert_start_n = 1'h0;
        wait_on(0, k);
        convert_start_n = 1'h1;
        wait_on(4, k);
        tick(120);
        convert_start_n = 1'h0;
        tick(150);
        chk_bit(ser.frame_sync_out, 1'h1, "sync not forced high");
        chk_rng(rx_cnt - seen, 0, 0, "cut frame counted");
        $display("test abort done");
        complete_run();
    end
endmodule

bind sacs_top sacs_assertions sacs_assertions_i (
    .clk(clk), .srst(srst), .sclk(sclk), .convert_start_n(convert_start_n),
    .use_internal_ref(use_internal_ref), .flash_therm(flash_therm),
    .ana(ana), .ser(ser));
